// file: design/sebl_boot_loader.v
// Serial EEPROM boot loader: reads the configuration image after PCI
// reset, stores it in the local register bank and holds off PCI access.
// Assumes the local processor bus is synchronous to core_clk_in and that
// the EEPROM pull-up and open-drain wire are resolved outside.
`timescale 1ns/1ps
`include "sebl_regs.vh"
module sebl_boot_loader (
  // Clock and reset
  input  wire       core_clk_in,
  input  wire       nrst_in,
  // Pins sampled during PCI reset
  input  wire       pci_rst_n_in,
  input  wire       id_load_strap_in,
  input  wire       pci_block_strap_in,
  // Two-wire link
  output wire       scl_out,
  input  wire       sda_in,
  output reg        sda_out,
  output wire       sda_oe_out,
  // PCI target hold-off
  output reg        pci_retry_out,
  // Local processor bus
  input  wire       lpb_sel_in,
  input  wire       lpb_wr_in,
  input  wire [4:0] lpb_addr_in,
  input  wire [7:0] lpb_wdata_in,
  output reg  [7:0] lpb_rdata_out,
  output reg        lpb_ack_out,
  // Status
  output reg        load_busy_out,
  output reg        load_done_out,
  output reg        load_error_out,
  output reg        access_block_out
);
  localparam [3:0] S_IDLE   = 4'h0;
  localparam [3:0] S_STOP0  = 4'h1;
  localparam [3:0] S_START0 = 4'h2;
  localparam [3:0] S_DEVW   = 4'h3;
  localparam [3:0] S_ADDR   = 4'h4;
  localparam [3:0] S_START1 = 4'h5;
  localparam [3:0] S_DEVR   = 4'h6;
  localparam [3:0] S_READ   = 4'h7;
  localparam [3:0] S_STOP1  = 4'h8;
  localparam [3:0] S_DONE   = 4'h9;

  // Image bytes 0..22; the control register sits at index 24
  reg  [7:0] cfg_mem [0:`SEBL_EXT_LEN-1];
  reg  [3:0] state_q;
  reg  [4:0] idx_q;
  reg        issued_q;
  reg        cmd_valid_q;
  reg  [1:0] cmd_d;
  reg  [7:0] wdata_d;
  reg        load_req_q;
  reg        prst_n_prev_q;
  reg        skip_next_q;
  wire [3:0] sync_w;
  wire       sda_s   = sync_w[0];
  wire       id_s    = sync_w[1];
  wire       block_s = sync_w[2];
  wire       prst_n_s = sync_w[3];
  wire       eng_busy;
  wire       eng_done;
  wire       eng_ack;
  wire [7:0] eng_rdata;
  wire       last_byte;
  wire       loading = load_busy_out;
  wire       cfg_hit = (lpb_addr_in < `SEBL_EXT_LEN);

  // ----------------------------------------
  // Gating decode
  // ----------------------------------------
  function [7:0] sebl_gate_mask;
    input [4:0] idx;
    begin
      case (idx)
        `SEBL_GATE_A: sebl_gate_mask = 8'h01 << `SEBL_GATE_A_BIT;
        `SEBL_GATE_B: sebl_gate_mask = 8'h01 << `SEBL_GATE_B_BIT;
        `SEBL_GATE_C: sebl_gate_mask = 8'h01 << `SEBL_GATE_C_BIT;
        default:      sebl_gate_mask = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  sebl_sync #(
    .W (4)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .async_in    ({pci_rst_n_in, pci_block_strap_in, id_load_strap_in, sda_in}),
    .sync_out    (sync_w)
  );

  sebl_twi_engine u_twi (
    .core_clk_in  (core_clk_in),
    .nrst_in      (nrst_in),
    .cmd_valid_in (cmd_valid_q),
    .cmd_in       (cmd_d),
    .wdata_in     (wdata_d),
    .ack_tx_in    (~last_byte),
    .busy_out     (eng_busy),
    .done_out     (eng_done),
    .ack_rx_out   (eng_ack),
    .rdata_out    (eng_rdata),
    .sda_sync_in  (sda_s),
    .scl_out      (scl_out),
    .sda_oe_out   (sda_oe_out)
  );

  // Last byte: twelfth without extension pattern, or twenty-third
  assign last_byte = ((idx_q == `SEBL_CONT_BYTE) && (eng_rdata[2:0] != `SEBL_CONT_PAT)) ||
                     (idx_q == (`SEBL_EXT_LEN - 5'h01));

  // ----------------------------------------
  // Command per state
  // ----------------------------------------
  always @*
  begin
    cmd_d   = `SEBL_CMD_STOP;
    wdata_d = 8'h00;
    case (state_q)
      S_STOP0:  cmd_d = `SEBL_CMD_STOP;
      S_START0: cmd_d = `SEBL_CMD_START;
      S_DEVW:
      begin
        cmd_d   = `SEBL_CMD_WRITE;
        wdata_d = {`SEBL_SEL_CODE, `SEBL_DIR_WR};
      end
      S_ADDR:
      begin
        cmd_d   = `SEBL_CMD_WRITE;
        wdata_d = `SEBL_BASE_ADDR;
      end
      S_START1: cmd_d = `SEBL_CMD_START;
      S_DEVR:
      begin
        cmd_d   = `SEBL_CMD_WRITE;
        wdata_d = {`SEBL_SEL_CODE, `SEBL_DIR_RD};
      end
      S_READ:   cmd_d = `SEBL_CMD_READ;
      S_STOP1:  cmd_d = `SEBL_CMD_STOP;
      default:  cmd_d = `SEBL_CMD_STOP;
    endcase
  end

  // ----------------------------------------
  // Load sequencer
  // ----------------------------------------
  always @(posedge core_clk_in)
  begin
    if (!nrst_in)
    begin
      state_q        <= S_IDLE;
      idx_q          <= 5'h00;
      issued_q       <= 1'b0;
      cmd_valid_q    <= 1'b0;
      load_req_q     <= 1'b0;
      prst_n_prev_q  <= 1'b0;
      skip_next_q    <= 1'b0;
      load_busy_out  <= 1'b0;
      load_done_out  <= 1'b0;
      load_error_out <= 1'b0;
    end
    else
    begin
      prst_n_prev_q <= prst_n_s;
      cmd_valid_q   <= 1'b0;
      if (!prst_n_s)
      begin
        // Straps and SDA are only meaningful while PCI reset is held
        state_q       <= S_IDLE;
        issued_q      <= 1'b0;
        load_busy_out <= 1'b0;
        load_req_q    <= sda_s | id_s;
      end
      // Start one cycle after the synchronised release of PCI reset
      else if (!prst_n_prev_q)
      begin
        if (load_req_q)
        begin
          state_q        <= S_STOP0;
          load_busy_out  <= 1'b1;
          load_done_out  <= 1'b0;
          load_error_out <= 1'b0;
          idx_q          <= 5'h00;
          skip_next_q    <= 1'b0;
        end
      end
      else if ((state_q != S_IDLE) && (state_q != S_DONE))
      begin
        // One command in flight; the next waits for its done pulse
        if (!issued_q && !eng_busy)
        begin
          cmd_valid_q <= 1'b1;
          issued_q    <= 1'b1;
        end
        else if (issued_q && eng_done)
        begin
          issued_q <= 1'b0;
          case (state_q)
            S_STOP0:  state_q <= S_START0;
            S_START0: state_q <= S_DEVW;
            S_DEVW, S_ADDR, S_DEVR:
            begin
              if (!eng_ack)
              begin
                state_q        <= S_STOP1;
                load_error_out <= 1'b1;
              end
              else
                state_q <= (state_q == S_DEVW) ? S_ADDR :
                           (state_q == S_ADDR) ? S_START1 : S_READ;
            end
            S_START1: state_q <= S_DEVR;
            S_READ:
            begin
              skip_next_q <= ((eng_rdata & sebl_gate_mask(idx_q)) == 8'h00) &&
                             (sebl_gate_mask(idx_q) != 8'h00);
              if (last_byte)
                state_q <= S_STOP1;
              else
                idx_q <= idx_q + 5'h01;
            end
            S_STOP1:
            begin
              state_q       <= S_DONE;
              load_busy_out <= 1'b0;
              load_done_out <= ~load_error_out;
            end
            default:  state_q <= S_IDLE;
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // Register bank and local bus
  // ----------------------------------------
  integer i;
  always @(posedge core_clk_in)
  begin
    if (!nrst_in)
    begin
      for (i = 0; i < `SEBL_EXT_LEN; i = i + 1)
        cfg_mem[i] <= 8'h00;
      access_block_out <= 1'b0;
      lpb_rdata_out    <= 8'h00;
      lpb_ack_out      <= 1'b0;
    end
    else
    begin
      // Refused accesses are still acknowledged so the host never stalls
      lpb_ack_out <= lpb_sel_in;
      if (lpb_sel_in && !lpb_wr_in)
      begin
        if (cfg_hit)
          lpb_rdata_out <= loading ? 8'h00 : cfg_mem[lpb_addr_in];
        else if (lpb_addr_in == `SEBL_MISC2_ADDR)
          lpb_rdata_out <= loading ? 8'h00 : {7'h00, access_block_out};
        else
          lpb_rdata_out <= 8'h00;
      end
      if (lpb_sel_in && lpb_wr_in && !loading)
      begin
        if (cfg_hit)
          cfg_mem[lpb_addr_in] <= lpb_wdata_in;
        else if (lpb_addr_in == `SEBL_MISC2_ADDR)
          access_block_out <= lpb_wdata_in[`SEBL_BLOCK_BIT];
      end
      // Gate bits are dropped; a closed gate skips the byte it guards
      if ((state_q == S_READ) && issued_q && eng_done && !skip_next_q)
        cfg_mem[idx_q] <= eng_rdata & ~sebl_gate_mask(idx_q);
      if ((state_q == S_READ) && issued_q && eng_done &&
          (idx_q == `SEBL_CONT_BYTE) && !eng_rdata[`SEBL_FLAG_BIT])
        access_block_out <= 1'b1;
      // Strap set comes last: it wins over a local clear in PCI reset
      if (!prst_n_s && block_s)
        access_block_out <= 1'b1;
    end
  end

  // ----------------------------------------
  // PCI hold-off and idle drive
  // ----------------------------------------
  always @(posedge core_clk_in)
  begin
    if (!nrst_in)
    begin
      pci_retry_out <= 1'b0;
      sda_out       <= 1'b0;
    end
    else
    begin
      // Open drain: only the enable toggles, the level stays low
      sda_out       <= 1'b0;
      // One cycle behind its sources; a PCI master is retried from then on
      pci_retry_out <= load_busy_out | access_block_out;
    end
  end
endmodule

// file: design/sebl_regs.vh
// Constants of the serial EEPROM boot loader: link timing, select code,
// load lengths, gating bits and the local register map.
// Assumes inclusion by bare name from each design file that needs it.
//
// Overview of operation
// - SDA or id-load strap high in PCI reset starts a twelve byte load.
// - Eleven more bytes follow only if byte twelve ends in 010.
// - The load is one sequential read burst, no re-addressing.
// - After START the seven-bit select code 1010000 is sent.
// - Data starts at EEPROM address zero and ascends.
// - After reset a STOP then a START precede the load.
// - PCI accesses get retry while registers are loading.
// - Local writes ignored, local reads give zero while loading.
// - Access-block strap high in reset sets the block bit; PCI retried.
// - Local host clears the block bit, then PCI cycles are accepted.
// - The load may set the block bit but never clears it.
// - EEPROM space is 256 bytes with eight-bit addresses.
// - Device masters the link: SCL output only, SDA two-way.
// - Loaded block flag zero sets the block bit; one leaves it.
// - Gating bits are not stored; they decide if related bits load.
`ifndef SEBL_REGS_VH
`define SEBL_REGS_VH
// ----------------------------------------
// Timing
// ----------------------------------------
`define SEBL_CLK_PERIOD_NS 8
`define SEBL_TWI_PERIOD_NS 160
`define SEBL_QTR_CYC ((`SEBL_TWI_PERIOD_NS + 4 * `SEBL_CLK_PERIOD_NS - 1) / (4 * `SEBL_CLK_PERIOD_NS))
// ----------------------------------------
// Link encoding
// ----------------------------------------
`define SEBL_CMD_START 2'h0
`define SEBL_CMD_STOP  2'h1
`define SEBL_CMD_WRITE 2'h2
`define SEBL_CMD_READ  2'h3
`define SEBL_SEL_CODE  7'h50
`define SEBL_DIR_WR    1'b0
`define SEBL_DIR_RD    1'b1
`define SEBL_ADDR_W    8
`define SEBL_BASE_ADDR 8'h00
// ----------------------------------------
// Load image
// ----------------------------------------
`define SEBL_BASE_LEN   5'h0c
`define SEBL_EXT_LEN    5'h17
`define SEBL_CONT_BYTE  5'h0b
`define SEBL_CONT_PAT   3'h2
`define SEBL_FLAG_BIT   3
`define SEBL_GATE_A     5'h04
`define SEBL_GATE_B     5'h07
`define SEBL_GATE_C     5'h08
`define SEBL_GATE_A_BIT 7
`define SEBL_GATE_B_BIT 5
`define SEBL_GATE_C_BIT 7
// ----------------------------------------
// Local register map
// ----------------------------------------
`define SEBL_MISC2_ADDR 5'h18
`define SEBL_BLOCK_BIT  0
`endif

// file: design/sebl_sync.v
// Two-flop synchroniser bank for levels from outside the core clock.
// Assumes each bit is a slow level; no pulse is guaranteed to pass.
`timescale 1ns/1ps
module sebl_sync #(
  parameter W = 4
) (
  input  wire         core_clk_in,
  input  wire         nrst_in,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1)
    begin : g_bit
      reg meta_q;
      reg stab_q;
      always @(posedge core_clk_in)
      begin
        if (!nrst_in)
        begin
          meta_q <= 1'b0;
          stab_q <= 1'b0;
        end
        else
        begin
          meta_q <= async_in[g];
          stab_q <= meta_q;
        end
      end
      assign sync_out[g] = stab_q;
    end
  endgenerate
endmodule

// file: design/sebl_twi_engine.v
// Two-wire bit engine: START, STOP, byte write with ack sample and
// byte read with ack drive. Four quarter phases per bit.
// Assumes sda_sync_in is already synchronised to core_clk_in.
`timescale 1ns/1ps
`include "sebl_regs.vh"
module sebl_twi_engine (
  // Clock and reset
  input  wire       core_clk_in,
  input  wire       nrst_in,
  // Command side
  input  wire       cmd_valid_in,
  input  wire [1:0] cmd_in,
  input  wire [7:0] wdata_in,
  input  wire       ack_tx_in,
  output reg        busy_out,
  output reg        done_out,
  output reg        ack_rx_out,
  output reg  [7:0] rdata_out,
  // Link side
  input  wire       sda_sync_in,
  output reg        scl_out,
  output reg        sda_oe_out
);
  localparam integer QTR_N    = `SEBL_QTR_CYC;
  localparam [2:0]   QTR_LAST = QTR_N[2:0] - 3'h1;
  reg [1:0] cmd_q;
  reg [3:0] bit_q;
  reg [1:0] ph_q;
  reg [2:0] tmr_q;
  reg [7:0] tx_q;
  reg       scl_d;
  reg       low_d;
  wire      is_byte = cmd_q[1];
  wire      tick    = (tmr_q == QTR_LAST);

  // ----------------------------------------
  // Line levels per phase
  // ----------------------------------------
  always @*
  begin
    scl_d = scl_out;
    low_d = sda_oe_out;
    if (busy_out)
    begin
      scl_d = (ph_q == 2'h1) || (ph_q == 2'h2) || ((cmd_q == `SEBL_CMD_STOP) && (ph_q == 2'h3));
      case (cmd_q)
        `SEBL_CMD_START: low_d = ph_q[1];
        `SEBL_CMD_STOP:  low_d = ~ph_q[1];
        `SEBL_CMD_WRITE: low_d = (bit_q != 4'h8) && !tx_q[7];
        `SEBL_CMD_READ:  low_d = (bit_q == 4'h8) && ack_tx_in;
        default:         low_d = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @(posedge core_clk_in)
  begin
    if (!nrst_in)
    begin
      busy_out   <= 1'b0;
      done_out   <= 1'b0;
      ack_rx_out <= 1'b0;
      rdata_out  <= 8'h00;
      scl_out    <= 1'b1;
      sda_oe_out <= 1'b0;
      cmd_q      <= 2'h0;
      bit_q      <= 4'h0;
      ph_q       <= 2'h0;
      tmr_q      <= 3'h0;
      tx_q       <= 8'h00;
    end
    else
    begin
      done_out   <= 1'b0;
      scl_out    <= scl_d;
      sda_oe_out <= low_d;
      if (!busy_out)
      begin
        if (cmd_valid_in)
        begin
          busy_out <= 1'b1;
          cmd_q    <= cmd_in;
          tx_q     <= wdata_in;
          bit_q    <= 4'h0;
          ph_q     <= 2'h0;
          tmr_q    <= 3'h0;
        end
      end
      else if (!tick)
        tmr_q <= tmr_q + 3'h1;
      else
      begin
        tmr_q <= 3'h0;
        ph_q  <= ph_q + 2'h1;
        // Sample late in the high phase, after the slave has settled
        if (is_byte && (ph_q == 2'h2))
        begin
          if (bit_q == 4'h8)
            ack_rx_out <= ~sda_sync_in;
          else
            rdata_out <= {rdata_out[6:0], sda_sync_in};
        end
        if (ph_q == 2'h3)
        begin
          if (!is_byte || (bit_q == 4'h8))
          begin
            busy_out <= 1'b0;
            done_out <= 1'b1;
          end
          else
          begin
            bit_q <= bit_q + 4'h1;
            tx_q  <= {tx_q[6:0], 1'b0};
          end
        end
      end
    end
  end
endmodule

// file: verif/sebl_boot_loader_props.sv
// Checker for the boot loader ports: hold-off, local bus, link shape.
// Assumes core_clk_in clocks every port it watches.
`timescale 1ns/1ps
module sebl_boot_loader_props (
  // Clock, reset and pins
  input wire       core_clk_in,
  input wire       nrst_in,
  input wire       pci_rst_n_in,
  input wire       id_load_strap_in,
  input wire       pci_block_strap_in,
  input wire       scl_out,
  input wire       sda_in,
  input wire       sda_out,
  input wire       sda_oe_out,
  input wire       pci_retry_out,
  // Local bus and status
  input wire       lpb_sel_in,
  input wire       lpb_wr_in,
  input wire [4:0] lpb_addr_in,
  input wire [7:0] lpb_wdata_in,
  input wire [7:0] lpb_rdata_out,
  input wire       lpb_ack_out,
  input wire       load_busy_out,
  input wire       load_done_out,
  input wire       load_error_out,
  input wire       access_block_out
);
  wire clr_w = lpb_sel_in & lpb_wr_in & (lpb_addr_in == 5'h18) & ~lpb_wdata_in[0];
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  chk_retry_on_load: assert property (load_busy_out |=> pci_retry_out)
    else $error("retry missing while loading");
  chk_retry_on_block: assert property (access_block_out |=> pci_retry_out)
    else $error("retry missing while blocked");
  chk_busy_read_zero: assert property (load_busy_out && lpb_sel_in && !lpb_wr_in |=> lpb_ack_out && lpb_rdata_out == 8'h00)
    else $error("local read during load not zero");
  chk_block_only_local: assert property ($fell(access_block_out) |-> $past(clr_w))
    else $error("block bit cleared without local write");
  chk_block_clear: assert property ((pci_rst_n_in [*8] ##0 (clr_w && !load_busy_out)) |=> !access_block_out ##1 !pci_retry_out)
    else $error("local clear of block bit not honoured");
  chk_sda_open_drain: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  chk_scl_high_width: assert property ($rose(scl_out) |-> scl_out [*8])
    else $error("serial clock high phase too short");
  chk_done_released: assert property ($rose(load_done_out) |-> ##[0:40] (scl_out && !sda_oe_out))
    else $error("link not stopped after load");
  chk_error_released: assert property ($rose(load_error_out) |-> ##[0:40] (scl_out && !sda_oe_out && !load_done_out))
    else $error("link not stopped after abort");
endmodule

bind sebl_boot_loader sebl_boot_loader_props chk_u (
  .core_clk_in(core_clk_in), .nrst_in(nrst_in), .pci_rst_n_in(pci_rst_n_in),
  .id_load_strap_in(id_load_strap_in), .pci_block_strap_in(pci_block_strap_in),
  .scl_out(scl_out), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .pci_retry_out(pci_retry_out), .lpb_sel_in(lpb_sel_in), .lpb_wr_in(lpb_wr_in),
  .lpb_addr_in(lpb_addr_in), .lpb_wdata_in(lpb_wdata_in), .lpb_rdata_out(lpb_rdata_out),
  .lpb_ack_out(lpb_ack_out), .load_busy_out(load_busy_out), .load_done_out(load_done_out),
  .load_error_out(load_error_out), .access_block_out(access_block_out)
);

// file: verif/sebl_boot_loader_tb_top.sv
// Bench: EEPROM image loads, local bus hold-off and the access block.
// Assumes the EEPROM model and bound checker are compiled first.
`timescale 1ns/1ps
module sebl_boot_loader_tb_top;
  reg         clk = 1'b0;
  reg         nrst = 1'b0;
  reg         prst_n = 1'b0;
  reg         id_s = 1'b0;
  reg         blk_s = 1'b0;
  reg         sel = 1'b0;
  reg         wr = 1'b0;
  reg  [4:0]  addr = 5'h00;
  reg  [7:0]  wdata = 8'h00;
  reg         nak = 1'b0;
  wire        scl, sda_o, sda_oe, retry, ack, busy, done, err, blk, pull;
  wire [7:0]  rdata;
  wire        sda_w = ~(sda_oe | pull);
  reg  [7:0]  regm [0:22];
  reg  [8:0]  exp_q [$];
  reg  [8:0]  e;
  reg  [31:0] rnd = 32'hf091;
  integer     n_errors = 0;
  integer     compares = 0;
  integer     i;
  always #4 clk = ~clk;
  sebl_boot_loader dut_u (
    .core_clk_in(clk), .nrst_in(nrst), .pci_rst_n_in(prst_n), .id_load_strap_in(id_s),
    .pci_block_strap_in(blk_s), .scl_out(scl), .sda_in(sda_w), .sda_out(sda_o),
    .sda_oe_out(sda_oe), .pci_retry_out(retry), .lpb_sel_in(sel), .lpb_wr_in(wr),
    .lpb_addr_in(addr), .lpb_wdata_in(wdata), .lpb_rdata_out(rdata), .lpb_ack_out(ack),
    .load_busy_out(busy), .load_done_out(done), .load_error_out(err), .access_block_out(blk)
  );
  sebl_eeprom_model eep_u (.scl_in(scl), .sda_in(sda_w), .nak_in(nak), .sda_pull_out(pull));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task check(input [8*10-1:0] name, input [7:0] seen, input [7:0] expv);
    begin
      compares = compares + 1;
      if (seen !== expv)
      begin
        n_errors = n_errors + 1;
        $display("ERROR %0s expected %h seen %h", name, expv, seen);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // Leaves the strobe up so the next call is back to back
  task lpb(input w, input [4:0] a, input [7:0] d, input [7:0] x);
    begin
      @(negedge clk);
      sel = 1'b1;
      wr = w;
      addr = a;
      wdata = d;
      exp_q.push_back({~w, x});
    end
  endtask
  task lpb_end;
    begin
      @(negedge clk);
      sel = 1'b0;
    end
  endtask
  task wait_busy(input v, input integer lim);
    integer k;
    begin
      k = 0;
      while (busy !== v && k < lim)
      begin
        @(negedge clk);
        k = k + 1;
      end
      if (busy !== v)
      begin
        check("busy_wait", {7'h00, busy}, {7'h00, v});
        give_verdict;
      end
    end
  endtask
  // --------------------------------------------------
  // Response monitor
  // --------------------------------------------------
  always @(negedge clk)
    if (nrst && ack === 1'b1)
    begin
      e = exp_q.pop_front();
      if (e[8])
        check("rdata", rdata, e[7:0]);
    end
  // --------------------------------------------------
  // One load: random image, strap options, hold-off checks
  // --------------------------------------------------
  task run_load(input [8*6-1:0] name, input [2:0] cont, input flag, input nk, input bs);
    integer n;
    begin
      for (i = 0; i < 256; i = i + 1)
      begin
        rnd = lfsr(rnd);
        eep_u.mem[i] = rnd[7:0];
      end
      eep_u.mem[11][3:0] = {flag, cont};
      eep_u.mem[4][7] = cont[1];
      eep_u.mem[7][5] = cont[1];
      eep_u.mem[8][7] = cont[1];
      nak = nk;
      @(negedge clk);
      prst_n = 1'b0;
      id_s = 1'b1;
      blk_s = bs;
      repeat (6) @(negedge clk);
      prst_n = 1'b1;
      wait_busy(1'b1, 20);
      id_s = 1'b0;
      blk_s = 1'b0;
      lpb(1'b1, 5'h0f, rnd[23:16], 8'h00);
      lpb(1'b0, 5'h00, 8'h00, 8'h00);
      lpb_end;
      check("retry", {7'h00, retry}, 8'h01);
      wait_busy(1'b0, 20000);
      repeat (3) @(negedge clk);
      check("done", {7'h00, done}, {7'h00, !nk});
      check("error", {7'h00, err}, {7'h00, nk});
      n = nk ? 0 : (cont == 3'h2 ? 23 : 12);
      for (i = 0; i < n; i = i + 1)
        if (!((i == 5 && !cont[1]) || (i == 8 && !cont[1]) || (i == 9 && !cont[1])))
          regm[i] = eep_u.mem[i] & ~((i == 4 || i == 8) ? 8'h80 : (i == 7 ? 8'h20 : 8'h00));
      for (i = 0; i < 24; i = i + 1)
        lpb(1'b0, i[4:0], 8'h00, i == 23 ? 8'h00 : regm[i]);
      lpb_end;
      check("block", {7'h00, blk}, {7'h00, bs | (!nk & !flag)});
      lpb(1'b1, 5'h18, rnd[15:8] & 8'hfe, 8'h00);
      lpb_end;
      repeat (2) @(negedge clk);
      check("block_clr", {7'h00, blk}, 8'h00);
      check("retry_clr", {7'h00, retry}, 8'h00);
      check("ack_left", (exp_q.size() == 0) ? 8'h00 : 8'h01, 8'h00);
      $display("test %0s done", name);
    end
  endtask
  // Local reset is never pulsed during a load
  initial
  begin
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    run_load("ext", 3'h2, 1'b1, 1'b0, 1'b0);
    run_load("strap", 3'h0, 1'b1, 1'b0, 1'b1);
    run_load("flag", 3'h0, 1'b0, 1'b0, 1'b0);
    run_load("nak", 3'h0, 1'b0, 1'b1, 1'b0);
    give_verdict;
  end
endmodule

// file: verif/sebl_eeprom_model.sv
// Two-wire configuration EEPROM: byte address write, sequential read.
// Assumes an open-drain wire with pull-up resolved by the bench.
`timescale 1ns/1ps
module sebl_eeprom_model (
  // Wire levels and fault control
  input  wire scl_in,
  input  wire sda_in,
  input  wire nak_in,
  // Pull-down request
  output reg  sda_pull_out
);
  reg [7:0] mem [0:255];
  reg [7:0] sh_q;
  reg [7:0] dout_q;
  reg [7:0] ptr_q = 8'h00;
  reg [3:0] bc_q = 4'h0;
  // States: 0 select, 1 address, 2 read, 3 idle, 4 wait restart
  reg [2:0] st_q = 3'h3;
  reg       ok_q = 1'b0;
  initial sda_pull_out = 1'b0;
  always @(negedge sda_in)
    if (scl_in)
    begin
      st_q = 3'h0;
      bc_q = 4'h0;
      sda_pull_out = 1'b0;
    end
  always @(posedge sda_in)
    if (scl_in)
      st_q = 3'h3;
  always @(posedge scl_in)
    if (st_q != 3'h3)
    begin
      if (bc_q < 4'h8)
        sh_q = {sh_q[6:0], sda_in};
      else if (st_q == 3'h2 && sda_in)
        st_q = 3'h3;
      bc_q = bc_q + 4'h1;
    end
  // Pull only while the clock is low, so no false START or STOP
  always @(negedge scl_in)
    if (st_q < 3'h3)
    begin
      if (bc_q == 4'h8 && st_q != 3'h2)
      begin
        ok_q = st_q == 3'h1 || (sh_q[7:1] == 7'h50 && !nak_in);
        if (st_q == 3'h1)
          ptr_q = sh_q;
        sda_pull_out = ok_q;
      end
      else if (bc_q == 4'h9)
      begin
        bc_q = 4'h0;
        if (!ok_q)
          st_q = 3'h3;
        else if (st_q == 3'h0)
          st_q = sh_q[0] ? 3'h2 : 3'h1;
        else if (st_q == 3'h1)
          st_q = 3'h4;
        if (st_q == 3'h2)
        begin
          dout_q = mem[ptr_q];
          ptr_q = ptr_q + 8'h01;
        end
        sda_pull_out = st_q == 3'h2 && !dout_q[7];
      end
      else if (st_q == 3'h2)
        sda_pull_out = bc_q < 4'h8 && !dout_q[3'h7 - bc_q[2:0]];
    end
endmodule
